// ---- sim/tb_motor_loop_config_registers.sv ----
// Purpose: self-checking bench for the motor loop configuration register bank
// Assumes: zero-wait apb slave, registers at index*4, unwritten words read zero
// Notes: a bench model of the three words predicts reads and field outputs
`timescale 1ns/100ps
module tb_motor_loop_config_registers;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'h0;
  logic [9:0] a_ckp = 10'h0, a_cki = 10'h0, a_skp = 10'h0, a_ski = 10'h0;
  wire [31:0] prdata;
  wire pready, pslverr, ckp_au, cki_au, skp_au, ski_au;
  wire [7:0] bemf, duty;
  wire [9:0] cqkp, cdkp, cki, skp, ski;
  wire [13:0] maxs;
  wire [11:0] hz;
  wire [1:0] mode;
  wire [6:0] pct;
  logic [31:0] rd, m[3];
  logic err;
  logic [11:0] adr[3];
  int err_total = 0;
  int tests_run = 0;
  always #12.5 clk = ~clk;
  mlcr_regs uut (.CLK_I(clk), .RESET_N_I(reset_n), .PSEL_I(psel), .PENABLE_I(penable),
    .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PSTRB_I(pstrb),
    .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr), .AUTO_CUR_KP_I(a_ckp),
    .AUTO_CUR_KI_I(a_cki), .AUTO_SPD_KP_I(a_skp), .AUTO_SPD_KI_I(a_ski),
    .BACK_EMF_CONSTANT_O(bemf), .CUR_Q_KP_O(cqkp), .CUR_D_KP_O(cdkp), .CUR_KI_O(cki),
    .SPD_KP_O(skp), .SPD_KI_O(ski), .CUR_KP_AUTO_O(ckp_au), .CUR_KI_AUTO_O(cki_au),
    .SPD_KP_AUTO_O(skp_au), .SPD_KI_AUTO_O(ski_au), .MAX_SPEED_O(maxs),
    .MAX_ELEC_HZ_O(hz), .PROFILE_MODE_O(mode), .PROFILE_TURN_ON_DUTY_O(duty),
    .TURN_ON_DUTY_PCT_O(pct));
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // one apb transfer, waits for pready, takes read data at that edge
  task automatic apb(input logic wr, input logic [11:0] ad, input logic [31:0] wd,
                     input logic [3:0] st);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= wd;
    pstrb <= st;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic check_all();
    logic [9:0] f;
    for (int i = 0; i < 3; i++) begin
      apb(1'b0, adr[i], 32'h0, 4'h0);
      chk("rdata", rd, m[i]);
      chk("pslverr", err, 1'b0);
    end
    chk("bemf", bemf, m[0][30:23]);
    f = m[0][22:13];
    chk("cur_q_kp", cqkp, f != 0 ? f : a_ckp);
    chk("cur_d_kp", cdkp, f != 0 ? f : a_ckp);
    chk("cur_kp_auto", ckp_au, f == 0);
    f = m[0][12:3];
    chk("cur_ki", cki, f != 0 ? f : a_cki);
    chk("cur_ki_auto", cki_au, f == 0);
    f = {m[0][2:0], m[1][30:24]};
    chk("spd_kp", skp, f != 0 ? f : a_skp);
    chk("spd_kp_auto", skp_au, f == 0);
    f = m[1][23:14];
    chk("spd_ki", ski, f != 0 ? f : a_ski);
    chk("spd_ki_auto", ski_au, f == 0);
    chk("max_speed", maxs, m[1][13:0]);
    chk("max_hz", hz, m[1][13:0] / 6);
    chk("mode", mode, m[2][30:29]);
    chk("duty", duty, m[2][28:21]);
    chk("duty_pct", pct, m[2][28:21] * 100 / 255);
  endtask
  task automatic wr_reg(input int i, input logic [31:0] wd, input logic [3:0] st);
    apb(1'b1, adr[i], wd, st);
    for (int b = 0; b < 4; b++) begin
      if (st[b]) m[i][8*b +: 8] = wd[8*b +: 8];
    end
    @(negedge clk);
    check_all();
  endtask
  initial begin
    #(25 * 20000);
    err_total++;
    end_of_test();
  end
  initial begin
    void'($urandom(32'h5a2d));
    adr = '{{2'b00, mlcr_pkg::GAINS_A_ADDR}, {2'b00, mlcr_pkg::GAINS_B_ADDR},
            {2'b00, mlcr_pkg::PROFILE1_ADDR}};
    m = '{default: 32'h0};
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    check_all();
    for (int k = 0; k < 40; k++) begin
      @(posedge clk);
      a_ckp <= 10'($urandom);
      a_cki <= 10'($urandom);
      a_skp <= 10'($urandom);
      a_ski <= 10'($urandom);
      wr_reg(k % 3, $urandom, k < 9 ? 4'hf : 4'($urandom));
    end
    wr_reg(0, 32'h8000_0000, 4'hf);
    wr_reg(1, 32'h0000_3fff, 4'hf);
    for (int md = 0; md < 4; md++) begin
      wr_reg(2, {1'b0, 2'(md), 8'hff, 21'h0}, 4'hf);
    end
    apb(1'b1, 12'h004, 32'hffff_ffff, 4'hf);
    chk("unmapped_err", err, 1'b1);
    apb(1'b0, 12'h004, 32'h0, 4'h0);
    chk("unmapped_rd", rd, 32'h0);
    wr_reg(0, 32'hffff_ffff, 4'hf);
    @(posedge clk);
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    m = '{default: 32'h0};
    check_all();
    end_of_test();
  end
endmodule

// ---- src/mlcr_pkg.sv ----
// Purpose: constants for the motor loop configuration register bank
// Assumes: apb slave, 32-bit data, registers at index*4
// Notes: offsets are word indices, byte address is index times four
package mlcr_pkg;
  // word indices (0x8e is not a multiple of four, so these are not byte addresses)
  localparam logic [7:0] GAINS_A_IDX = 8'h8c;
  localparam logic [7:0] GAINS_B_IDX = 8'h8e;
  localparam logic [7:0] PROFILE1_IDX = 8'h94;
  localparam logic [9:0] GAINS_A_ADDR = {GAINS_A_IDX, 2'b00};
  localparam logic [9:0] GAINS_B_ADDR = {GAINS_B_IDX, 2'b00};
  localparam logic [9:0] PROFILE1_ADDR = {PROFILE1_IDX, 2'b00};
  // reset values
  localparam logic [31:0] GAINS_A_RST = 32'h0000_0000;
  localparam logic [31:0] GAINS_B_RST = 32'h0000_0000;
  localparam logic [31:0] PROFILE1_RST = 32'h0000_0000;
  // field positions
  localparam int PARITY_POS = 31;
  localparam int BEMF_LSB = 23;
  localparam int CKP_LSB = 13;
  localparam int CKI_LSB = 3;
  localparam int SKP_HI_LSB = 0;
  localparam int SKP_LO_LSB = 24;
  localparam int SKI_LSB = 14;
  localparam int MAXSPD_LSB = 0;
  localparam int PROF_MODE_LSB = 29;
  localparam int DUTY_ON_LSB = 21;
  // maximum speed scale: electrical hz = field / 6
  localparam logic [13:0] MAXSPD_DIV = 14'h0006;
  // turn-on duty scale: percent = field * 100 / 255
  localparam logic [15:0] PCT_SCALE = 16'h0064;
  localparam logic [15:0] DUTY_FULL = 16'h00ff;
  typedef enum logic [1:0] {
    PROF_SPEED_REF,
    PROF_LINEAR,
    PROF_STAIRCASE,
    PROF_FWD_REV
  } mlcr_profile_t;
endpackage

// ---- src/mlcr_regs.sv ----
// Purpose: configuration register bank for a sensorless motor control loop
// Assumes: apb master, zero-wait slave, single clock, synchronous active-low reset
// Notes: gains given as mantissa (8 lsb) and decade exponent (2 msb)
`timescale 1ns/100ps
module mlcr_regs (
  input wire logic CLK_I,
  input wire logic RESET_N_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [11:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  input wire logic [3:0] PSTRB_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  input wire logic [9:0] AUTO_CUR_KP_I,
  input wire logic [9:0] AUTO_CUR_KI_I,
  input wire logic [9:0] AUTO_SPD_KP_I,
  input wire logic [9:0] AUTO_SPD_KI_I,
  output logic [7:0] BACK_EMF_CONSTANT_O,
  output logic [9:0] CUR_Q_KP_O,
  output logic [9:0] CUR_D_KP_O,
  output logic [9:0] CUR_KI_O,
  output logic [9:0] SPD_KP_O,
  output logic [9:0] SPD_KI_O,
  output logic CUR_KP_AUTO_O,
  output logic CUR_KI_AUTO_O,
  output logic SPD_KP_AUTO_O,
  output logic SPD_KI_AUTO_O,
  output logic [13:0] MAX_SPEED_O,
  output logic [11:0] MAX_ELEC_HZ_O,
  output logic [1:0] PROFILE_MODE_O,
  output logic [7:0] PROFILE_TURN_ON_DUTY_O,
  output logic [6:0] TURN_ON_DUTY_PCT_O
);
  logic [31:0] gains_a_q;
  logic [31:0] gains_b_q;
  logic [31:0] profile_q;
  logic [31:0] rdata_q;
  logic err_q;
  logic access;
  logic hit_a;
  logic hit_b;
  logic hit_p;
  logic [31:0] bmask;
  logic [9:0] current_prop_gain;
  logic [9:0] current_integral_gain;
  logic [9:0] speed_prop_gain;
  logic [9:0] speed_integral_gain;
  logic [13:0] max_speed;
  logic [15:0] duty_prod;

  assign access = PSEL_I && PENABLE_I;
  assign hit_a = PADDR_I[11:2] == {2'b00, mlcr_pkg::GAINS_A_IDX};
  assign hit_b = PADDR_I[11:2] == {2'b00, mlcr_pkg::GAINS_B_IDX};
  assign hit_p = PADDR_I[11:2] == {2'b00, mlcr_pkg::PROFILE1_IDX};
  assign bmask = {{8{PSTRB_I[3]}}, {8{PSTRB_I[2]}}, {8{PSTRB_I[1]}}, {8{PSTRB_I[0]}}};

  // register writes, byte lanes honoured
  always_ff @(posedge CLK_I) begin
    if (!RESET_N_I) begin
      gains_a_q <= mlcr_pkg::GAINS_A_RST;
    end else if (access && PWRITE_I && hit_a) begin
      gains_a_q <= (gains_a_q & ~bmask) | (PWDATA_I & bmask);
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RESET_N_I) begin
      gains_b_q <= mlcr_pkg::GAINS_B_RST;
    end else if (access && PWRITE_I && hit_b) begin
      gains_b_q <= (gains_b_q & ~bmask) | (PWDATA_I & bmask);
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RESET_N_I) begin
      profile_q <= mlcr_pkg::PROFILE1_RST;
    end else if (access && PWRITE_I && hit_p) begin
      profile_q <= (profile_q & ~bmask) | (PWDATA_I & bmask);
    end
  end

  // read data and error, registered at the setup-phase edge (PSEL_I high, PENABLE_I low)
  always_ff @(posedge CLK_I) begin
    if (!RESET_N_I) begin
      rdata_q <= 32'h0000_0000;
      err_q <= 1'b0;
    end else if (PSEL_I && !PENABLE_I) begin
      err_q <= !(hit_a || hit_b || hit_p);
      if (hit_a) begin
        rdata_q <= gains_a_q;
      end else if (hit_b) begin
        rdata_q <= gains_b_q;
      end else if (hit_p) begin
        rdata_q <= profile_q;
      end else begin
        rdata_q <= 32'h0000_0000;
      end
    end
  end

  assign PRDATA_O = rdata_q;
  assign PREADY_O = 1'b1;
  assign PSLVERR_O = access && err_q;

  // field extraction
  assign BACK_EMF_CONSTANT_O = gains_a_q[mlcr_pkg::BEMF_LSB +: 8];
  assign current_prop_gain = gains_a_q[mlcr_pkg::CKP_LSB +: 10];
  assign current_integral_gain = gains_a_q[mlcr_pkg::CKI_LSB +: 10];
  assign speed_prop_gain = {gains_a_q[mlcr_pkg::SKP_HI_LSB +: 3],
                            gains_b_q[mlcr_pkg::SKP_LO_LSB +: 7]};
  assign speed_integral_gain = gains_b_q[mlcr_pkg::SKI_LSB +: 10];
  assign max_speed = gains_b_q[mlcr_pkg::MAXSPD_LSB +: 14];

  // one selector per gain, so each field overrides only its own auto value
  logic [9:0] cur_kp;
  mlcr_gain_sel #(
    .WIDTH(10)
  ) u_cur_kp (
    .clk_i(CLK_I),
    .field_i(current_prop_gain),
    .auto_gain_i(AUTO_CUR_KP_I),
    .gain_o(cur_kp),
    .auto_o(CUR_KP_AUTO_O)
  );
  assign CUR_Q_KP_O = cur_kp;
  assign CUR_D_KP_O = cur_kp;

  mlcr_gain_sel #(
    .WIDTH(10)
  ) u_cur_ki (
    .clk_i(CLK_I),
    .field_i(current_integral_gain),
    .auto_gain_i(AUTO_CUR_KI_I),
    .gain_o(CUR_KI_O),
    .auto_o(CUR_KI_AUTO_O)
  );

  mlcr_gain_sel #(
    .WIDTH(10)
  ) u_spd_kp (
    .clk_i(CLK_I),
    .field_i(speed_prop_gain),
    .auto_gain_i(AUTO_SPD_KP_I),
    .gain_o(SPD_KP_O),
    .auto_o(SPD_KP_AUTO_O)
  );

  mlcr_gain_sel #(
    .WIDTH(10)
  ) u_spd_ki (
    .clk_i(CLK_I),
    .field_i(speed_integral_gain),
    .auto_gain_i(AUTO_SPD_KI_I),
    .gain_o(SPD_KI_O),
    .auto_o(SPD_KI_AUTO_O)
  );

  // derived values
  assign MAX_SPEED_O = max_speed;
  logic [13:0] hz_full;
  logic [11:0] max_elec_hz_q;
  assign hz_full = max_speed / mlcr_pkg::MAXSPD_DIV;

  // quotient is at most 2730, so the top two bits are always zero
  always_ff @(posedge CLK_I) begin
    max_elec_hz_q <= hz_full[11:0];
  end
  assign MAX_ELEC_HZ_O = max_elec_hz_q;

  mlcr_pkg::mlcr_profile_t profile_mode;
  assign profile_mode =
    mlcr_pkg::mlcr_profile_t'(profile_q[mlcr_pkg::PROF_MODE_LSB +: 2]);
  assign PROFILE_MODE_O = profile_mode;

  assign PROFILE_TURN_ON_DUTY_O = profile_q[mlcr_pkg::DUTY_ON_LSB +: 8];
  assign duty_prod = 16'(PROFILE_TURN_ON_DUTY_O) * mlcr_pkg::PCT_SCALE;
  logic [15:0] pct_full;
  logic [6:0] duty_pct_q;
  assign pct_full = duty_prod / mlcr_pkg::DUTY_FULL;

  // quotient is at most 100, fits seven bits
  always_ff @(posedge CLK_I) begin
    duty_pct_q <= pct_full[6:0];
  end
  assign TURN_ON_DUTY_PCT_O = duty_pct_q;

  // checks
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RESET_N_I);

  sequence s_write_a;
    access && PWRITE_I && hit_a && (PSTRB_I == 4'hf);
  endsequence

  sequence s_write_b;
    access && PWRITE_I && hit_b && (PSTRB_I == 4'hf);
  endsequence

  sequence s_write_p;
    access && PWRITE_I && hit_p && (PSTRB_I == 4'hf);
  endsequence

  sequence s_keep_top_a;
    access && PWRITE_I && hit_a && !PSTRB_I[3];
  endsequence

  // register writes land in their fields, the strobe-off top byte of gains a keeps its value, reset clears gains a
  a_bemf_written: assert property (s_write_a |=> BACK_EMF_CONSTANT_O == $past(PWDATA_I[30:23]))
    else $error("back emf constant not written");
  a_lane_kept: assert property (s_keep_top_a |=> gains_a_q[31:24] == $past(gains_a_q[31:24]))
    else $error("strobe-off byte of gains a changed");
  a_parity_kept: assert property (s_write_a |=> gains_a_q[mlcr_pkg::PARITY_POS] == $past(PWDATA_I[31]))
    else $error("parity bit not stored");
  a_maxspd_written: assert property (s_write_b |=> MAX_SPEED_O == $past(PWDATA_I[13:0]))
    else $error("maximum speed not written");
  a_mode_written: assert property (s_write_p |=> PROFILE_MODE_O == $past(PWDATA_I[30:29]))
    else $error("profile mode not written");
  a_duty_written: assert property (s_write_p |=> PROFILE_TURN_ON_DUTY_O == $past(PWDATA_I[28:21]))
    else $error("turn on duty not written");
  a_reset_zero: assert property (@(posedge CLK_I) disable iff (1'b0)
                                 !RESET_N_I |=> gains_a_q == 32'h0000_0000)
    else $error("gains a not cleared by reset");

  // gain selection, outputs one cycle behind the registers
  a_dq_same: assert property (CUR_Q_KP_O == CUR_D_KP_O)
    else $error("q and d proportional gains differ");
  a_ckp_auto: assert property (CUR_KP_AUTO_O == ($past(gains_a_q[22:13]) == 10'h000))
    else $error("current kp auto flag wrong");
  a_ckp_auto_use: assert property (CUR_KP_AUTO_O |-> CUR_D_KP_O == $past(AUTO_CUR_KP_I))
    else $error("current kp auto not used");
  a_cki_pass: assert property (!CUR_KI_AUTO_O |-> CUR_KI_O == $past(gains_a_q[12:3]))
    else $error("current ki not from register");
  a_cki_auto_use: assert property (CUR_KI_AUTO_O |-> CUR_KI_O == $past(AUTO_CUR_KI_I))
    else $error("current ki auto not used");
  a_skp_split: assert property (s_write_a |-> ##2 (SPD_KP_AUTO_O
                                 || SPD_KP_O[9:7] == $past(PWDATA_I[2:0], 2)))
    else $error("speed kp upper bits wrong");
  a_skp_low: assert property (!SPD_KP_AUTO_O |-> SPD_KP_O[6:0] == $past(gains_b_q[30:24]))
    else $error("speed kp lower bits wrong");
  a_skp_auto: assert property (SPD_KP_AUTO_O |-> SPD_KP_O == $past(AUTO_SPD_KP_I))
    else $error("speed kp auto not used");
  a_ski_auto: assert property (SPD_KI_AUTO_O == ($past(gains_b_q[23:14]) == 10'h000))
    else $error("speed ki auto flag wrong");
  a_ski_pass: assert property (!SPD_KI_AUTO_O |-> SPD_KI_O == $past(gains_b_q[23:14]))
    else $error("speed ki not from register");
  a_ski_auto_use: assert property (SPD_KI_AUTO_O |-> SPD_KI_O == $past(AUTO_SPD_KI_I))
    else $error("speed ki auto not used");
  a_ckp_override: assert property (!CUR_KP_AUTO_O |-> CUR_Q_KP_O == $past(gains_a_q[22:13]))
    else $error("current kp override wrong");

  // derived values, one cycle behind the registers
  a_maxspd_hz: assert property (32'(MAX_ELEC_HZ_O) * 32'h6 <= 32'($past(MAX_SPEED_O))
                                 && 32'($past(MAX_SPEED_O)) < 32'(MAX_ELEC_HZ_O + 12'h1) * 32'h6)
    else $error("max electrical speed wrong");
  a_duty_pct: assert property (TURN_ON_DUTY_PCT_O <= 7'h64)
    else $error("turn on duty percent above 100");
  a_duty_scale: assert property (
    32'(TURN_ON_DUTY_PCT_O) * 32'hff <= 32'($past(PROFILE_TURN_ON_DUTY_O)) * 32'h64
    && 32'($past(PROFILE_TURN_ON_DUTY_O)) * 32'h64 < 32'(TURN_ON_DUTY_PCT_O + 7'h1) * 32'hff)
    else $error("turn on duty percent scale wrong");
endmodule

module mlcr_gain_sel #(
  parameter int WIDTH = 10
) (
  input wire logic clk_i,
  input wire logic [WIDTH-1:0] field_i,
  input wire logic [WIDTH-1:0] auto_gain_i,
  output logic [WIDTH-1:0] gain_o,
  output logic auto_o
);
  logic auto_d;
  logic [WIDTH-1:0] gain_d;
  logic auto_q;
  logic [WIDTH-1:0] gain_q;

  // a zero field hands the gain back to the loop's own calculation
  assign auto_d = field_i == '0;
  assign gain_d = auto_d ? auto_gain_i : field_i;

  // gain and flag registered on the same edge so they never disagree
  always_ff @(posedge clk_i) begin
    gain_q <= gain_d;
  end

  always_ff @(posedge clk_i) begin
    auto_q <= auto_d;
  end

  assign gain_o = gain_q;
  assign auto_o = auto_q;
endmodule
